// File: fcs_pkg.sv
package fcs_pkg;

   // ==========================================================
   // Command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PROGRAM = 8'h41;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
   localparam logic [7:0] CMD_LOCK_PROGRAM = 8'h77;
   localparam logic [7:0] CMD_READ_LOCK = 8'h71;
   localparam logic [7:0] CMD_BLANK_CHECK = 8'h25;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;

   // ==========================================================
   // Address map
   localparam int PADDR_W = 17;
   localparam int REG_SEL_BIT = 16;
   localparam logic [16:0] REG_A_OFS = 17'h1_0000;
   localparam logic [16:0] REG_B_OFS = 17'h1_0004;

   // ==========================================================
   // Field positions
   localparam int A_READY_BIT = 0;
   localparam int A_INPLACE_BIT = 1;
   localparam int A_LOCKDIS_BIT = 2;
   localparam int A_PRGERR_BIT = 6;
   localparam int A_ERSERR_BIT = 7;
   localparam int B_LOCKRES_BIT = 6;
   localparam int STAT_READY_BIT = 7;
   localparam int STAT_ERASE_BIT = 5;
   localparam int STAT_PROGRAM_BIT = 4;

   // ==========================================================
   // Values after reset
   localparam logic LOCKRES_RST = 1'b1;
   localparam logic LOCKBIT_RST = 1'b1;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int PROG_TIME_NS = 20000;
   localparam int ERASE_TIME_NS = 1000000;
   localparam int CHECK_TIME_NS = 5000;
   localparam int LOCK_TIME_NS = 20000;
   localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CHECK_CYCLES_DEF = (CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_CYCLES_DEF = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // States and operations
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_PRG_LO = 5'b00010,
      ST_PRG_HI = 5'b00100,
      ST_CONFIRM = 5'b01000,
      ST_BUSY = 5'b10000
   } fcs_state_e;

   typedef enum logic [4:0] {
      OP_PROGRAM = 5'b00001,
      OP_ERASE = 5'b00010,
      OP_LOCK = 5'b00100,
      OP_READ_LOCK = 5'b01000,
      OP_BLANK = 5'b10000
   } fcs_op_e;

endpackage : fcs_pkg

// File: fcs_op_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_op_timer
   import fcs_pkg::*;
#(
   parameter int CNT_W = 32
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [CNT_W-1:0] load,
   output logic busy,
   output logic done
);

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic busy_r;
   logic busy_nxt;
   logic done_r;
   logic done_nxt;

   // ==========================================================
   // Down counter: done pulses once after load cycles.
   always_comb begin
      count_nxt = count_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (start) begin
         count_nxt = load;
         busy_nxt = 1'b1;
      end else if (busy_r) begin
         if (count_r <= CNT_W'(1)) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end else begin
            count_nxt = count_r - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy = busy_r;
   assign done = done_r;

endmodule : fcs_op_timer
`default_nettype wire

// File: fcs_array.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_array
   import fcs_pkg::*;
#(
   parameter int WORDS = 256,
   parameter int BLOCK_WORDS = 64,
   localparam int IDX_W = $clog2(WORDS),
   localparam int OFS_W = $clog2(BLOCK_WORDS),
   localparam int BLK_W = IDX_W - OFS_W
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [15:0] rd_data,
   input wire logic prg_en,
   input wire logic [IDX_W-1:0] prg_idx,
   input wire logic [31:0] prg_data,
   input wire logic ers_en,
   input wire logic [BLK_W-1:0] blk_idx,
   output logic pair_erased,
   output logic blk_blank
);

   logic [15:0] mem [WORDS];
   logic [IDX_W-1:0] lo_idx;
   logic [IDX_W-1:0] hi_idx;

   assign lo_idx = {prg_idx[IDX_W-1:1], 1'b0};
   assign hi_idx = {prg_idx[IDX_W-1:1], 1'b1};
   assign rd_data = mem[rd_idx];
   assign pair_erased = (mem[lo_idx] == ERASED_WORD) && (mem[hi_idx] == ERASED_WORD);

   // ==========================================================
   // Blank detection over the selected block.
   always_comb begin
      blk_blank = 1'b1;
      for (int i = 0; i < BLOCK_WORDS; i++) begin
         if (mem[{blk_idx, OFS_W'(i)}] != ERASED_WORD) begin
            blk_blank = 1'b0;
         end
      end
   end

   // ==========================================================
   // Cell array, erased after reset.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < WORDS; i++) begin
            mem[i] <= ERASED_WORD;
         end
      end else if (ers_en) begin
         for (int i = 0; i < BLOCK_WORDS; i++) begin
            mem[{blk_idx, OFS_W'(i)}] <= ERASED_WORD;
         end
      end else if (prg_en) begin
         mem[lo_idx] <= prg_data[15:0];
         mem[hi_idx] <= prg_data[31:16];
      end
   end

endmodule : fcs_array
`default_nettype wire

// File: fcs_sequencer.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer
   import fcs_pkg::*;
#(
   parameter int WORDS = 256,
   parameter int BLOCK_WORDS = 64,
   parameter int PROG_CYCLES = PROG_CYCLES_DEF,
   parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
   parameter int CHECK_CYCLES = CHECK_CYCLES_DEF,
   parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   localparam int IDX_W = $clog2(WORDS);
   localparam int OFS_W = $clog2(BLOCK_WORDS);
   localparam int BLK_W = IDX_W - OFS_W;
   localparam int BLOCKS = WORDS / BLOCK_WORDS;
   localparam int FLASH_AW = IDX_W + 1;

   // ==========================================================
   // Parameter checks
   generate
      if ((WORDS != (1 << IDX_W)) || (BLOCK_WORDS != (1 << OFS_W)) || (BLOCKS < 2)
          || (FLASH_AW > REG_SEL_BIT) || (BLOCK_WORDS < 2)) begin : g_bad_geom
         $error("Flash geometry must be powers of two with at least two blocks.");
      end
      if ((PROG_CYCLES < 1) || (ERASE_CYCLES < 1) || (CHECK_CYCLES < 1)
          || (LOCK_CYCLES < 1)) begin : g_bad_time
         $error("Operation cycle counts must be at least one.");
      end
   endgenerate

   // ==========================================================
   // Declarations
   fcs_state_e state_r;
   fcs_state_e state_nxt;
   fcs_op_e op_r;
   fcs_op_e op_nxt;
   logic [IDX_W-1:0] addr_r;
   logic [IDX_W-1:0] addr_nxt;
   logic [15:0] wlo_r;
   logic [15:0] wlo_nxt;
   logic [31:0] wdata_r;
   logic [31:0] wdata_nxt;
   logic status_mode_r;
   logic status_mode_nxt;
   logic prg_err_r;
   logic prg_err_nxt;
   logic ers_err_r;
   logic ers_err_nxt;
   logic lock_res_r;
   logic lock_res_nxt;
   logic lock_dis_r;
   logic lock_dis_nxt;
   logic inplace_r;
   logic inplace_nxt;
   logic [BLOCKS-1:0] lock_bits_r;
   logic [BLOCKS-1:0] lock_bits_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pslverr_r;
   logic pslverr_nxt;

   logic setup;
   logic wr_acc;
   logic reg_sel;
   logic flash_ok;
   logic [IDX_W-1:0] bus_idx;
   logic [BLK_W-1:0] bus_blk;
   logic [BLK_W-1:0] op_blk;
   logic [7:0] cmd;
   logic any_err;
   logic seq_ready_flag;
   logic [7:0] status_read_byte;
   logic tmr_start;
   logic [31:0] tmr_load;
   logic tmr_busy;
   logic tmr_done;
   logic arr_prg;
   logic arr_ers;
   logic [15:0] arr_rd;
   logic pair_erased;
   logic blk_blank;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;
   assign reg_sel = paddr[REG_SEL_BIT];
   assign flash_ok = !reg_sel && (paddr[0] == 1'b0)
                     && (paddr[REG_SEL_BIT-1:FLASH_AW] == '0);
   assign bus_idx = paddr[FLASH_AW-1:1];
   assign bus_blk = bus_idx[IDX_W-1:OFS_W];
   assign op_blk = addr_r[IDX_W-1:OFS_W];
   assign cmd = pwdata[7:0];
   assign any_err = prg_err_r || ers_err_r;
   assign seq_ready_flag = (state_r != ST_BUSY);
   assign status_read_byte = {seq_ready_flag, 1'b0, ers_err_r, prg_err_r, 4'h0};

   // ==========================================================
   // Helpers
   fcs_op_timer #(
      .CNT_W(32)
   ) u_timer (
      .clk(pclk),
      .rstn(presetn),
      .start(tmr_start),
      .load(tmr_load),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   fcs_array #(
      .WORDS(WORDS),
      .BLOCK_WORDS(BLOCK_WORDS)
   ) u_array (
      .clk(pclk),
      .rstn(presetn),
      .rd_idx(bus_idx),
      .rd_data(arr_rd),
      .prg_en(arr_prg),
      .prg_idx(addr_r),
      .prg_data(wdata_r),
      .ers_en(arr_ers),
      .blk_idx(op_blk),
      .pair_erased(pair_erased),
      .blk_blank(blk_blank)
   );

   // ==========================================================
   // Command sequencer
   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      wlo_nxt = wlo_r;
      wdata_nxt = wdata_r;
      status_mode_nxt = status_mode_r;
      prg_err_nxt = prg_err_r;
      ers_err_nxt = ers_err_r;
      lock_res_nxt = lock_res_r;
      lock_bits_nxt = lock_bits_r;
      tmr_start = 1'b0;
      tmr_load = 32'h0000_0001;
      arr_prg = 1'b0;
      arr_ers = 1'b0;
      unique case (state_r)
         ST_IDLE: begin
            if (wr_acc && flash_ok) begin
               addr_nxt = bus_idx;
               if (cmd == CMD_READ_ARRAY) begin
                  status_mode_nxt = 1'b0;
               end else if (cmd == CMD_READ_STATUS) begin
                  status_mode_nxt = 1'b1;
               end else if (cmd == CMD_CLEAR_STATUS) begin
                  prg_err_nxt = 1'b0;
                  ers_err_nxt = 1'b0;
               end else if (cmd == CMD_READ_LOCK) begin
                  status_mode_nxt = 1'b0;
                  if (!any_err) begin
                     op_nxt = OP_READ_LOCK;
                     state_nxt = ST_CONFIRM;
                  end
               end else if (cmd == CMD_PROGRAM || cmd == CMD_BLOCK_ERASE
                            || cmd == CMD_LOCK_PROGRAM || cmd == CMD_BLANK_CHECK) begin
                  if (!any_err) begin
                     op_nxt = (cmd == CMD_PROGRAM) ? OP_PROGRAM :
                              (cmd == CMD_BLOCK_ERASE) ? OP_ERASE :
                              (cmd == CMD_LOCK_PROGRAM) ? OP_LOCK : OP_BLANK;
                     state_nxt = (cmd == CMD_PROGRAM) ? ST_PRG_LO : ST_CONFIRM;
                  end
               end else begin
                  prg_err_nxt = 1'b1;
                  ers_err_nxt = 1'b1;
               end
            end
         end
         ST_PRG_LO: begin
            if (wr_acc && flash_ok) begin
               wlo_nxt = pwdata[15:0];
               state_nxt = ST_PRG_HI;
            end
         end
         ST_PRG_HI: begin
            if (wr_acc && flash_ok) begin
               wdata_nxt = {pwdata[15:0], wlo_r};
               state_nxt = ST_IDLE;
               if (!lock_bits_r[addr_r[IDX_W-1:OFS_W]] && !lock_dis_r) begin
                  prg_err_nxt = 1'b1;
               end else begin
                  tmr_start = 1'b1;
                  tmr_load = 32'(PROG_CYCLES);
                  state_nxt = ST_BUSY;
                  if (!inplace_r) begin
                     status_mode_nxt = 1'b1;
                  end
               end
            end
         end
         ST_CONFIRM: begin
            if (wr_acc && flash_ok) begin
               addr_nxt = bus_idx;
               state_nxt = ST_IDLE;
               if (cmd == CMD_READ_ARRAY) begin
                  status_mode_nxt = 1'b0;
               end else if (cmd != CMD_CONFIRM) begin
                  prg_err_nxt = 1'b1;
                  ers_err_nxt = 1'b1;
               end else if (op_r == OP_BLANK && !lock_bits_r[bus_blk]) begin
                  ers_err_nxt = 1'b1;
               end else if (op_r == OP_ERASE && !lock_bits_r[bus_blk] && !lock_dis_r) begin
                  ers_err_nxt = 1'b1;
               end else begin
                  tmr_start = 1'b1;
                  state_nxt = ST_BUSY;
                  unique case (op_r)
                     OP_ERASE: tmr_load = 32'(ERASE_CYCLES);
                     OP_LOCK: tmr_load = 32'(LOCK_CYCLES);
                     default: tmr_load = 32'(CHECK_CYCLES);
                  endcase
                  if (!inplace_r && op_r != OP_READ_LOCK) begin
                     status_mode_nxt = 1'b1;
                  end
               end
            end
         end
         ST_BUSY: begin
            if (tmr_done) begin
               state_nxt = ST_IDLE;
               unique case (op_r)
                  OP_PROGRAM: begin
                     arr_prg = pair_erased;
                     prg_err_nxt = !pair_erased;
                  end
                  OP_ERASE: begin
                     arr_ers = 1'b1;
                     lock_bits_nxt[op_blk] = 1'b1;
                     ers_err_nxt = 1'b0;
                  end
                  OP_LOCK: lock_bits_nxt[op_blk] = 1'b0;
                  OP_READ_LOCK: lock_res_nxt = lock_bits_r[op_blk];
                  default: ers_err_nxt = !blk_blank;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         op_r <= OP_PROGRAM;
         addr_r <= '0;
         wlo_r <= 16'h0000;
         wdata_r <= 32'h0000_0000;
         status_mode_r <= 1'b0;
         prg_err_r <= 1'b0;
         ers_err_r <= 1'b0;
         lock_res_r <= LOCKRES_RST;
         lock_bits_r <= {BLOCKS{LOCKBIT_RST}};
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         wlo_r <= wlo_nxt;
         wdata_r <= wdata_nxt;
         status_mode_r <= status_mode_nxt;
         prg_err_r <= prg_err_nxt;
         ers_err_r <= ers_err_nxt;
         lock_res_r <= lock_res_nxt;
         lock_bits_r <= lock_bits_nxt;
      end
   end

   // ==========================================================
   // APB slave: response prepared in the setup cycle.
   always_comb begin
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      lock_dis_nxt = lock_dis_r;
      inplace_nxt = inplace_r;
      if (setup) begin
         prdata_nxt = 32'h0000_0000;
         pslverr_nxt = 1'b0;
         if (paddr == REG_A_OFS) begin
            prdata_nxt[A_READY_BIT] = seq_ready_flag;
            prdata_nxt[A_INPLACE_BIT] = inplace_r;
            prdata_nxt[A_LOCKDIS_BIT] = lock_dis_r;
            prdata_nxt[A_PRGERR_BIT] = prg_err_r;
            prdata_nxt[A_ERSERR_BIT] = ers_err_r;
         end else if (paddr == REG_B_OFS) begin
            prdata_nxt[B_LOCKRES_BIT] = lock_res_r;
         end else if (flash_ok) begin
            prdata_nxt[15:0] = status_mode_r ? {8'h00, status_read_byte} : arr_rd;
         end else begin
            pslverr_nxt = 1'b1;
         end
      end
      if (wr_acc && paddr == REG_A_OFS) begin
         lock_dis_nxt = pwdata[A_LOCKDIS_BIT];
         inplace_nxt = pwdata[A_INPLACE_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         lock_dis_r <= 1'b0;
         inplace_r <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         pready_r <= setup;
         pslverr_r <= pslverr_nxt;
         lock_dis_r <= lock_dis_nxt;
         inplace_r <= inplace_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

endmodule : fcs_sequencer
`default_nettype wire

// File: fcs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_chk
   import fcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ==========================================================
   // Bus phases
   logic setup;
   logic flash;
   assign setup = psel && !penable;
   assign flash = !paddr[REG_SEL_BIT];
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_clear;
      psel && penable && pready && !pslverr && pwrite && flash
         && pwdata[7:0] == CMD_CLEAR_STATUS;
   endsequence
   sequence s_ctla_rd;
      setup && !pwrite && paddr == REG_A_OFS;
   endsequence
   // ==========================================================
   // Checks
   a_access_ready: assert property (setup |=> pready)
      else $error("access phase not answered at once");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_answer_cause: assert property ($rose(pready) |-> $past(setup))
      else $error("pready without a setup cycle");
   a_err_qual: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_odd_flash: assert property (setup && flash && paddr[0] |=> pslverr)
      else $error("odd flash address accepted");
   a_unmapped_reg: assert property (setup && !flash && paddr != REG_A_OFS
      && paddr != REG_B_OFS |=> pslverr)
      else $error("unmapped register accepted");
   a_flash_upper: assert property (setup && flash && !pwrite |=> prdata[31:16] == 16'h0)
      else $error("flash read upper half not zero");
   a_ctlb_rsvd: assert property (setup && !pwrite && paddr == REG_B_OFS
      |=> prdata[31:7] == 25'h0 && prdata[5:0] == 6'h0)
      else $error("second control register reserved bits set");
   a_clear_flags: assert property (s_clear ##[1:2] s_ctla_rd |=> prdata[7:6] == 2'h0)
      else $error("error flags not cleared");
endmodule : fcs_chk
`default_nettype wire

// File: fcs_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_cpu
   import fcs_pkg::*;
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [PADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   localparam int BLK_BYTES = 128;
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = '0;
      pwdata = '0;
   end
   // Released address and data lines show the inverse of the last value so nothing stale looks valid.
   task automatic xfer(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
   task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'h1, a, d, q, e);
   endtask : wr
   task automatic wait_ready();
      logic [31:0] q;
      logic e;
      q = 32'h0;
      while (q[A_READY_BIT] !== 1'h1)
         xfer(1'h0, REG_A_OFS, 32'h0, q, e);
   endtask : wait_ready
   // The model stays in RAM-executed mode and never stops the main clock.
   task automatic set_ctl(input logic [31:0] d);
      wr(REG_A_OFS, d & ~32'h2);
   endtask : set_ctl
   task automatic cmd2(input logic [7:0] code, input logic [7:0] second, input int blk);
      logic [PADDR_W-1:0] ba;
      ba = PADDR_W'(blk * BLK_BYTES + BLK_BYTES - 2);
      wr(ba, {24'h0, code});
      wr(ba, {24'h0, second});
   endtask : cmd2
   task automatic write_pair(input logic [PADDR_W-1:0] a, input logic [31:0] d);
      logic [PADDR_W-1:0] wa;
      wa = a & ~17'h3;
      wr(wa, {16'h0, 8'($urandom), CMD_PROGRAM});
      wr(wa, {16'h0, d[15:0]});
      wr(wa, {16'h0, d[31:16]});
   endtask : write_pair
   task automatic erase(input int blk);
      logic [31:0] q;
      logic e;
      for (int i = 0; i < 3; i++) begin
         cmd2(CMD_BLOCK_ERASE, CMD_CONFIRM, blk);
         wait_ready();
         xfer(1'h0, REG_A_OFS, 32'h0, q, e);
         if (q[A_ERSERR_BIT] !== 1'h1)
            break;
         wr(17'h0, 32'h50);
      end
   endtask : erase
endmodule : fcs_cpu
`default_nettype wire

// File: test_flash_command_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_command_sequencer import fcs_pkg::*;;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   logic [15:0] mem [256];
   always #25 pclk = ~pclk;
   fcs_sequencer #(.PROG_CYCLES(8), .ERASE_CYCLES(20)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   fcs_cpu u_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ==========================================================
   // Checking helpers
   function automatic logic [31:0] ctl_exp(logic rdy, logic pe, logic ee, logic ld);
      return {24'h0, ee, pe, 3'h0, ld, 1'h0, rdy};
   endfunction : ctl_exp
   function automatic logic [31:0] st_exp(logic rdy, logic ee, logic pe);
      return {24'h0, rdy, 1'h0, ee, pe, 4'h0};
   endfunction : st_exp
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [16:0] a, input logic [31:0] d,
         input logic [31:0] eq, input logic ee, input string m);
      logic [31:0] q;
      logic e;
      u_cpu.xfer(w, a, d, q, e);
      if (!w && !ee)
         chk(q, eq, m);
      chk({31'h0, e}, {31'h0, ee}, m);
   endtask : acc
   task automatic rdc(input logic [16:0] a, input logic [31:0] eq, input string m);
      acc(1'h0, a, 32'h0, eq, 1'h0, m);
   endtask : rdc
   task automatic clr();
      u_cpu.wr(17'h0, 32'h50);
   endtask : clr
   task automatic op(input logic [7:0] code, input int blk);
      u_cpu.cmd2(code, CMD_CONFIRM, blk);
      u_cpu.wait_ready();
   endtask : op
   task automatic prog_chk(input logic [16:0] a, input logic [31:0] d);
      logic ok;
      ok = mem[a[8:1]] === 16'hFFFF && mem[a[8:1] + 1] === 16'hFFFF;
      u_cpu.write_pair(a, d);
      rdc(17'h0, st_exp(1'h0, 1'h0, 1'h0), "busy status");
      u_cpu.wait_ready();
      rdc(17'h2, st_exp(1'h1, 1'h0, !ok), "program result");
      if (ok)
         {mem[a[8:1] + 1], mem[a[8:1]]} = d;
      u_cpu.wr(17'h0, 32'hFF);
      rdc(a, {16'h0, mem[a[8:1]]}, "low word");
      rdc(a + 17'h2, {16'h0, mem[a[8:1] + 1]}, "high word");
      clr();
   endtask : prog_chk
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // ==========================================================
   // Tests
   initial begin
      void'($urandom(4779));
      for (int i = 0; i < 256; i++)
         mem[i] = 16'hFFFF;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      rdc(REG_A_OFS, ctl_exp(1'h1, 1'h0, 1'h0, 1'h0), "control after reset");
      rdc(REG_B_OFS, 32'h40, "lock result after reset");
      rdc(17'h0, 32'hFFFF, "erased word");
      acc(1'h0, 17'h1_0008, 32'h0, 32'h0, 1'h1, "unmapped register");
      acc(1'h1, 17'h3, 32'h33, 32'h0, 1'h1, "odd address");
      acc(1'h1, REG_B_OFS, 32'hFFFF_FFFF, 32'h0, 1'h0, "lock result write");
      rdc(REG_A_OFS, ctl_exp(1'h1, 1'h0, 1'h0, 1'h0), "no effect of errors");
      rdc(REG_B_OFS, 32'h40, "lock result read only");
      $display("test reset done");
      prog_chk(17'(($urandom % 32) * 4), $urandom);
      prog_chk(17'h10, $urandom);
      prog_chk(17'h10, $urandom);
      u_cpu.wr(17'h0, 32'h33);
      u_cpu.wr(17'h0, {24'h0, CMD_PROGRAM});
      rdc(REG_A_OFS, ctl_exp(1'h1, 1'h1, 1'h1, 1'h0), "refused in error");
      clr();
      rdc(REG_A_OFS, ctl_exp(1'h1, 1'h0, 1'h0, 1'h0), "cleared");
      $display("test program done");
      u_cpu.cmd2(CMD_BLOCK_ERASE, CMD_CONFIRM, 0);
      rdc(17'h4, st_exp(1'h0, 1'h0, 1'h0), "erase busy");
      u_cpu.wait_ready();
      rdc(17'h6, st_exp(1'h1, 1'h0, 1'h0), "erase result");
      op(CMD_READ_LOCK, 0);
      for (int i = 0; i < 64; i++)
         mem[i] = 16'hFFFF;
      rdc(17'h10, 32'hFFFF, "erased after lock query");
      $display("test erase done");
      op(CMD_LOCK_PROGRAM, 1);
      op(CMD_READ_LOCK, 1);
      rdc(REG_B_OFS, 32'h0, "locked block");
      op(CMD_READ_LOCK, 2);
      rdc(REG_B_OFS, 32'h40, "unlocked block");
      u_cpu.write_pair(17'h80, $urandom);
      rdc(REG_A_OFS, ctl_exp(1'h1, 1'h1, 1'h0, 1'h0), "locked program");
      clr();
      u_cpu.cmd2(CMD_BLOCK_ERASE, CMD_CONFIRM, 1);
      rdc(REG_A_OFS, ctl_exp(1'h1, 1'h0, 1'h1, 1'h0), "locked erase");
      clr();
      for (int ld = 0; ld < 2; ld++) begin
         u_cpu.set_ctl(32'(ld) << A_LOCKDIS_BIT);
         op(CMD_BLANK_CHECK, 1);
         rdc(REG_A_OFS, ctl_exp(1'h1, 1'h0, 1'h1, 1'(ld)), "locked blank");
         clr();
      end
      u_cpu.erase(1);
      op(CMD_READ_LOCK, 1);
      rdc(REG_B_OFS, 32'h40, "erase unlocks");
      u_cpu.set_ctl(32'h0);
      $display("test lock done");
      op(CMD_BLANK_CHECK, 3);
      rdc(REG_A_OFS, ctl_exp(1'h1, 1'h0, 1'h0, 1'h0), "blank block");
      prog_chk(17'(384 + ($urandom % 32) * 4), $urandom);
      op(CMD_BLANK_CHECK, 3);
      rdc(REG_A_OFS, ctl_exp(1'h1, 1'h0, 1'h1, 1'h0), "not blank");
      clr();
      u_cpu.cmd2(CMD_BLOCK_ERASE, 8'h12, 0);
      rdc(REG_A_OFS, ctl_exp(1'h1, 1'h1, 1'h1, 1'h0), "bad second code");
      clr();
      u_cpu.cmd2(CMD_LOCK_PROGRAM, CMD_READ_ARRAY, 0);
      rdc(17'h10, {16'h0, mem[8]}, "command dropped");
      u_cpu.wr(17'h0, 32'hAB70);
      rdc(17'(($urandom % 256) * 2), st_exp(1'h1, 1'h0, 1'h0), "status mode");
      u_cpu.wr(17'h0, 32'hFF);
      $display("test commands done");
      repeat (8)
         prog_chk(17'(256 + ($urandom % 8) * 4), $urandom);
      $display("test random done");
      print_verdict();
   end
endmodule : test_flash_command_sequencer
bind fcs_sequencer fcs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
`default_nettype wire
